/* File: core/ecc_map.vh */
// Register offsets, field positions, reset values and timing of the edge counter
`ifndef ECC_MAP_VH
`define ECC_MAP_VH

// ==========================================================
// Register byte offsets
`define ECC_OFF_CTRL      8'h00
`define ECC_OFF_PRES_CNT  8'h04
`define ECC_OFF_PRES_CMP  8'h08
`define ECC_OFF_NEXT_CMP  8'h0C
`define ECC_OFF_COUNT     8'h10
`define ECC_OFF_COMP      8'h14
`define ECC_OFF_STATUS    8'h18
`define ECC_OFF_IRQ_STAT  8'h1C
`define ECC_OFF_IRQ_MASK  8'h20
`define ECC_OFF_UPDATE    8'h24
`define ECC_OFF_LIVE_CNT  8'h28

// ==========================================================
// Control register fields
`define ECC_CTRL_UP_EN    0
`define ECC_CTRL_DN_EN    1
`define ECC_CTRL_DO_EN    2
`define ECC_CTRL_DO_OFF   3
`define ECC_CTRL_IRQ_EN   4
`define ECC_CTRL_RELOAD   5
`define ECC_CTRL_SET_CMP  6
`define ECC_CTRL_AUTO_UPD 7
`define ECC_CTRL_CNT_EN   8
`define ECC_CTRL_LD_CNT   9
`define ECC_CTRL_LD_CMP   10
`define ECC_CTRL_W        11
`define ECC_CTRL_RST      11'h0_000

// ==========================================================
// Status and interrupt fields
`define ECC_ST_STATUS_A   0
`define ECC_ST_DO_A       1
`define ECC_IRQ_CMP       0
`define ECC_IRQ_GATE      1
`define ECC_IRQ_WRAP      2
`define ECC_IRQ_W         3
`define ECC_IRQ_RST       3'h0
`define ECC_MASK_RST      3'h0

// ==========================================================
// Interrupt coalescing window
`define ECC_COALESCE_US   100
`define ECC_CLK_MHZ       25
`define ECC_COAL_CYC      12'h9C4

`endif

/* File: core/ecc_edge.v */
// Rising and falling edge detector for one synchronous input
`timescale 1ns/100ps
module ecc_edge
(
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_in,
  output wire o_rise,
  output wire o_fall
);

  reg prev_r;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      prev_r <= 1'b0;
    else
      prev_r <= i_in;
  end

  assign o_rise = i_in & ~prev_r;
  assign o_fall = ~i_in & prev_r;

endmodule

/* File: core/ecc_counter.v */
// Up/down edge counter with start/stop gate, one compare channel and APB registers
`timescale 1ns/100ps
`include "ecc_map.vh"

// What this block does
// - Each rising edge on the up input adds one while counting is enabled and direction is high.
// - Direction high: up input increments, down input decrements the count.
// - Gate input low suspends counting; gate high again resumes it.
// - Compare event only on a step from compare minus one to compare.
// - With off action, output A goes inactive at the compare event.
// - Status A is high while count is at or above compare value.
// - Down input deactivated: it never changes the count.
// - Interrupt option off: the compare event raises no interrupt.
// - Reload option off: count is kept at the compare event.
// - Set-compare option off: compare value kept after the event.
// - Auto update copies count, compare and status at each cycle point.
// - Events within 100 us share one interrupt start.
module ecc_counter
#(
  parameter W = 32
)
(
  input  wire          i_clk,
  input  wire          i_rst,
  input  wire          i_up,
  input  wire          i_down,
  input  wire          i_dir,
  input  wire          i_gate,
  input  wire          i_cycle_pt,
  output wire          o_do_a,
  output wire          o_irq,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr
);

  localparam [11:0] COAL_CYC = `ECC_COAL_CYC;

  // ==========================================================
  // Edge detection
  wire up_rise;
  wire dn_rise;
  wire gate_fall;

  ecc_edge u_up
  (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_in   (i_up),
    .o_rise (up_rise),
    .o_fall ()
  );

  ecc_edge u_dn
  (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_in   (i_down),
    .o_rise (dn_rise),
    .o_fall ()
  );

  ecc_edge u_gate
  (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_in   (i_gate),
    .o_rise (),
    .o_fall (gate_fall)
  );

  // ==========================================================
  // Registers
  reg [`ECC_CTRL_W-1:0] ctrl_r;
  reg [`ECC_CTRL_W-1:0] ctrl_prev_r;
  reg [W-1:0]           pres_cnt_r;
  reg [W-1:0]           pres_cmp_r;
  reg [W-1:0]           next_cmp_r;
  reg [W-1:0]           count_r;
  reg [W-1:0]           count_nxt;
  reg [W-1:0]           comp_r;
  reg [W-1:0]           comp_nxt;
  reg                   do_r;
  reg                   do_nxt;
  reg [W-1:0]           snap_cnt_r;
  reg [W-1:0]           snap_cmp_r;
  reg [1:0]             snap_st_r;
  reg [`ECC_IRQ_W-1:0]  irq_stat_r;
  reg [`ECC_IRQ_W-1:0]  irq_mask_r;
  reg [11:0]            coal_r;
  reg                   irq_r;
  reg                   cmp_evt;
  reg                   wrap_evt;
  reg                   up_step;
  reg                   dn_step;

  function at_or_above;
    input [W-1:0] val;
    input [W-1:0] lim;
    begin
      at_or_above = ($signed(val) >= $signed(lim));
    end
  endfunction

  // ==========================================================
  // APB decode
  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  reg  mapped;

  always @*
  begin
    if (paddr == `ECC_OFF_CTRL)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_PRES_CNT)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_PRES_CMP)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_NEXT_CMP)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_COUNT)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_COMP)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_STATUS)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_IRQ_STAT)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_IRQ_MASK)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_UPDATE)
      mapped = 1'b1;
    else if (paddr == `ECC_OFF_LIVE_CNT)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire wr_ok    = wr_en & mapped;
  wire ld_cnt   = ctrl_r[`ECC_CTRL_LD_CNT] & ~ctrl_prev_r[`ECC_CTRL_LD_CNT];
  wire ld_cmp   = ctrl_r[`ECC_CTRL_LD_CMP] & ~ctrl_prev_r[`ECC_CTRL_LD_CMP];
  wire cnt_on   = ctrl_r[`ECC_CTRL_CNT_EN] & i_gate;
  wire status_a = at_or_above(count_r, comp_r);
  wire upd_now  = (i_cycle_pt & ctrl_r[`ECC_CTRL_AUTO_UPD]) |
                  (wr_ok & (paddr == `ECC_OFF_UPDATE));

  // ==========================================================
  // Counting and compare
  always @*
  begin
    up_step   = cnt_on & ctrl_r[`ECC_CTRL_UP_EN] & up_rise;
    dn_step   = cnt_on & ctrl_r[`ECC_CTRL_DN_EN] & dn_rise;
    count_nxt = count_r;
    comp_nxt  = comp_r;
    do_nxt    = do_r;
    cmp_evt   = 1'b0;
    wrap_evt  = 1'b0;
    if ((up_step ^ dn_step) && (up_step == i_dir))
    begin
      count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
      wrap_evt  = (count_nxt == {1'b1, {(W-1){1'b0}}});
      cmp_evt   = (count_nxt == comp_r);
    end
    else if (up_step ^ dn_step)
    begin
      count_nxt = count_r - {{(W-1){1'b0}}, 1'b1};
      wrap_evt  = (count_r == {1'b1, {(W-1){1'b0}}});
    end
    if (cmp_evt)
    begin
      do_nxt = ~ctrl_r[`ECC_CTRL_DO_OFF];
      if (ctrl_r[`ECC_CTRL_RELOAD])
        count_nxt = pres_cnt_r;
      if (ctrl_r[`ECC_CTRL_SET_CMP])
        comp_nxt = next_cmp_r;
    end
    else if (status_a && !at_or_above(count_nxt, comp_r))
      do_nxt = ctrl_r[`ECC_CTRL_DO_OFF];
    if (ld_cnt)
    begin
      count_nxt = pres_cnt_r;
      do_nxt    = ctrl_r[`ECC_CTRL_DO_OFF];
    end
    if (ld_cmp)
      comp_nxt = pres_cmp_r;
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_r <= {W{1'b0}};
      comp_r  <= {W{1'b0}};
      do_r    <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      comp_r  <= comp_nxt;
      do_r    <= do_nxt;
    end
  end

  assign o_do_a = do_r & ctrl_r[`ECC_CTRL_DO_EN];

  // ==========================================================
  // Software registers
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_r      <= `ECC_CTRL_RST;
      ctrl_prev_r <= `ECC_CTRL_RST;
      pres_cnt_r  <= {W{1'b0}};
      pres_cmp_r  <= {W{1'b0}};
      next_cmp_r  <= {W{1'b0}};
      irq_mask_r  <= `ECC_MASK_RST;
    end
    else
    begin
      ctrl_prev_r <= ctrl_r;
      if (wr_ok && paddr == `ECC_OFF_CTRL)
        ctrl_r <= pwdata[`ECC_CTRL_W-1:0];
      else if (wr_ok && paddr == `ECC_OFF_PRES_CNT)
        pres_cnt_r <= pwdata[W-1:0];
      else if (wr_ok && paddr == `ECC_OFF_PRES_CMP)
        pres_cmp_r <= pwdata[W-1:0];
      else if (wr_ok && paddr == `ECC_OFF_NEXT_CMP)
        next_cmp_r <= pwdata[W-1:0];
      else if (wr_ok && paddr == `ECC_OFF_IRQ_MASK)
        irq_mask_r <= pwdata[`ECC_IRQ_W-1:0];
    end
  end

  // ==========================================================
  // Host-visible snapshot
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      snap_cnt_r <= {W{1'b0}};
      snap_cmp_r <= {W{1'b0}};
      snap_st_r  <= 2'h0;
    end
    else if (upd_now)
    begin
      snap_cnt_r <= count_r;
      snap_cmp_r <= comp_r;
      snap_st_r  <= {o_do_a, status_a};
    end
  end

  // ==========================================================
  // Interrupt status, mask and coalescing
  wire [`ECC_IRQ_W-1:0] irq_set = {wrap_evt, gate_fall,
                                   cmp_evt & ctrl_r[`ECC_CTRL_IRQ_EN]};
  wire [`ECC_IRQ_W-1:0] irq_clr = (wr_ok && paddr == `ECC_OFF_IRQ_STAT) ?
                                  pwdata[`ECC_IRQ_W-1:0] : `ECC_IRQ_RST;
  wire                  pend    = |(irq_stat_r & irq_mask_r);

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_stat_r <= `ECC_IRQ_RST;
      coal_r     <= 12'h000;
      irq_r      <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (!pend)
      begin
        coal_r <= 12'h000;
        irq_r  <= 1'b0;
      end
      else if (coal_r == COAL_CYC - 12'h001)
        irq_r <= 1'b1;
      else
        coal_r <= coal_r + 12'h001;
    end
  end

  assign o_irq = irq_r & pend;

  // ==========================================================
  // Read data
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
      prdata <= 32'h0000_0000;
      if (paddr == `ECC_OFF_CTRL)
        prdata[`ECC_CTRL_W-1:0] <= ctrl_r;
      else if (paddr == `ECC_OFF_PRES_CNT)
        prdata[W-1:0] <= pres_cnt_r;
      else if (paddr == `ECC_OFF_PRES_CMP)
        prdata[W-1:0] <= pres_cmp_r;
      else if (paddr == `ECC_OFF_NEXT_CMP)
        prdata[W-1:0] <= next_cmp_r;
      else if (paddr == `ECC_OFF_COUNT)
        prdata[W-1:0] <= snap_cnt_r;
      else if (paddr == `ECC_OFF_COMP)
        prdata[W-1:0] <= snap_cmp_r;
      else if (paddr == `ECC_OFF_STATUS)
        prdata[1:0] <= snap_st_r;
      else if (paddr == `ECC_OFF_IRQ_STAT)
        prdata[`ECC_IRQ_W-1:0] <= irq_stat_r;
      else if (paddr == `ECC_OFF_IRQ_MASK)
        prdata[`ECC_IRQ_W-1:0] <= irq_mask_r;
      else if (paddr == `ECC_OFF_LIVE_CNT)
        prdata[W-1:0] <= count_r;
    end
  end

endmodule

/* File: bench/ecc_chk_sva.sv */
// Port-level assertions for the edge counter
`timescale 1ns/100ps
module ecc_chk
(
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_up,
  input wire        i_down,
  input wire        i_gate,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        o_do_a,
  input wire        o_irq,
  input wire        pready,
  input wire        pslverr
);
  wire act = i_up | i_down | psel;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================
  // Bus answers
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_err_unmap; psel && penable && paddr > 8'h28 |-> pslverr; endproperty
  a_err_unmap: assert property (p_err_unmap) else $error("unmapped access not refused");
  property p_err_map; psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("mapped access refused");
  property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // ==========================================
  // Output and interrupt behaviour
  property p_irq_hold; o_irq && !(psel && penable && pwrite) |=> o_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_do_cause; $changed(o_do_a) |-> $past(act, 1) || $past(act, 2) || $past(act, 3) || $past(act, 4);
  endproperty
  a_do_cause: assert property (p_do_cause) else $error("output A moved uncaused");
  property p_gate_quiet; (!i_gate && !psel) [*6] |=> $stable(o_do_a); endproperty
  a_gate_quiet: assert property (p_gate_quiet) else $error("output A moved while gated");
endmodule
bind ecc_counter ecc_chk ecc_chk_i (.i_clk(i_clk), .i_rst(i_rst), .i_up(i_up), .i_down(i_down), .i_gate(i_gate),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .o_do_a(o_do_a),
  .o_irq(o_irq), .pready(pready), .pslverr(pslverr));

/* File: bench/ecc_src.sv */
// Pulse sensor model: a burst of clean pulses on request
`timescale 1ns/100ps
module ecc_src
(
  input  wire       i_clk,
  input  wire       i_go,
  input  wire [8:0] i_num,
  output wire       o_pulse,
  output wire       o_busy
);
  reg [9:0] left_r = 10'h000;
  always @(posedge i_clk)
  begin
    if (i_go)
      left_r <= {i_num, 1'b0};
    else if (left_r != 10'h000)
      left_r <= left_r - 10'h001;
  end
  assign o_pulse = left_r[0];
  assign o_busy  = (left_r != 10'h000);
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the edge counter
`timescale 1ns/100ps
module tb_top;
  reg          clk = 1'b0;
  reg          rst = 1'b1;
  reg          dir = 1'b1;
  reg          gate = 1'b1;
  reg          cpt = 1'b0;
  reg          sel_dn = 1'b0;
  reg          go = 1'b0;
  reg  [8:0]   num = 9'h000;
  reg          psel = 1'b0;
  reg          penable = 1'b0;
  reg          pwrite = 1'b0;
  reg  [7:0]   paddr = 8'h00;
  reg  [31:0]  pwdata = 32'h0000_0000;
  wire         pulse, busy, do_a, irq, pready, pslverr;
  wire [31:0]  prdata;
  integer      errors = 0;
  integer      cmp_count = 0;
  integer      seed = 32'h0000_4c10;
  logic [31:0] exq[$];
  ecc_counter ecc_counter_i (.i_clk(clk), .i_rst(rst), .i_up(pulse & ~sel_dn), .i_down(pulse & sel_dn),
    .i_dir(dir), .i_gate(gate), .i_cycle_pt(cpt), .o_do_a(do_a), .o_irq(irq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ecc_src ecc_src_i (.i_clk(clk), .i_go(go), .i_num(num), .o_pulse(pulse), .o_busy(busy));
  initial
    forever #20 clk = ~clk;
  // ==========================================
  // Report and compare
  task test_done;
  begin
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task hang;
  begin
    errors = errors + 1;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    test_done;
  end
  endtask
  // Read data checked against expected values taken off the queue by the monitor
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready)
      chk(prdata, exq.pop_front());
  end
  // ==========================================
  // Bus and pulse drivers
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
  begin
    if (!w)
      exq.push_back(d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40)
    begin
      n = n + 1;
      @(posedge clk);
    end
    if (n == 40)
      hang;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task pulses(input [8:0] n);
    integer t;
  begin
    @(posedge clk);
    go <= 1'b1;
    num <= n;
    @(posedge clk);
    go <= 1'b0;
    t = 0;
    @(posedge clk);
    while (busy && t < 1200)
    begin
      t = t + 1;
      @(posedge clk);
    end
    if (t == 1200)
      hang;
    repeat (4) @(posedge clk);
  end
  endtask
  task snap;
  begin
    @(posedge clk);
    cpt <= 1'b1;
    @(posedge clk);
    cpt <= 1'b0;
  end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin : main
    integer t;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1, 8'h20, 32'h0000_0007);
    apb(1, 8'h04, 32'h0000_0000);
    apb(1, 8'h08, 32'h0000_00FA);
    apb(1, 8'h00, 32'h0000_018D);
    apb(1, 8'h00, 32'h0000_078D);
    apb(0, 8'h28, 32'h0000_0000);
    chk({31'h0, do_a}, 32'h0000_0001);
    pulses(9'd249);
    apb(0, 8'h28, 32'h0000_00F9);
    sel_dn <= 1'b1;
    pulses(9'd3);
    sel_dn <= 1'b0;
    apb(0, 8'h28, 32'h0000_00F9);
    apb(1, 8'h04, 32'h0000_0005);
    apb(1, 8'h00, 32'h0000_078D);
    apb(0, 8'h28, 32'h0000_00F9);
    @(posedge clk);
    gate <= 1'b0;
    pulses(9'd1 + ($random(seed) & 7));
    apb(0, 8'h28, 32'h0000_00F9);
    chk({31'h0, irq}, 32'h0000_0000);
    gate <= 1'b1;
    pulses(9'd1);
    chk({31'h0, do_a}, 32'h0000_0000);
    apb(0, 8'h28, 32'h0000_00FA);
    apb(0, 8'h1C, 32'h0000_0002);
    snap;
    apb(0, 8'h10, 32'h0000_00FA);
    apb(0, 8'h18, 32'h0000_0001);
    apb(0, 8'h14, 32'h0000_00FA);
    pulses(9'd2);
    dir <= 1'b0;
    pulses(9'd3);
    snap;
    apb(0, 8'h18, 32'h0000_0002);
    apb(0, 8'h10, 32'h0000_00F9);
    dir <= 1'b1;
    apb(1, 8'h00, 32'h0000_078F);
    sel_dn <= 1'b1;
    pulses(9'd1);
    apb(0, 8'h28, 32'h0000_00F8);
    apb(0, 8'h30, 32'h0000_0000);
    t = 0;
    while (!irq && t < 3000)
    begin
      t = t + 1;
      @(posedge clk);
    end
    if (t == 3000)
      hang;
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1, 8'h20, 32'h0000_0000);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1, 8'h20, 32'h0000_0007);
    apb(1, 8'h1C, 32'h0000_0002);
    apb(0, 8'h1C, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // Reload, new compare value and compare interrupt enabled
    apb(1, 8'h0C, 32'h0000_0100);
    apb(1, 8'h00, 32'h0000_07FD);
    sel_dn <= 1'b0;
    pulses(9'd2);
    apb(0, 8'h28, 32'h0000_0005);
    apb(1, 8'h24, 32'h0000_0000);
    apb(0, 8'h14, 32'h0000_0100);
    apb(0, 8'h1C, 32'h0000_0001);
    test_done;
  end
endmodule
